//--- nvst_pkg.sv
// Purpose: shared constants for the nonvolatile store/recall sequencer
// Assumes: 200 MHz core clock
// Notes:   times kept in printed units, cycle counts derived from them
package nvst_pkg;

  // ----------------------------------------------------------------
  // clock rate
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 200;  // core clock rate
  localparam int CLK_PERIOD_NS = 5;    // core clock period

  // ----------------------------------------------------------------
  // printed times, own units
  // ----------------------------------------------------------------
  localparam int T_DELAY_NS     = 25;  // write grace on store start
  localparam int T_STORE_MS     = 8;   // longest store
  localparam int T_RECALL_US    = 600; // longest software recall
  localparam int T_FA_HI_MS     = 20;  // power-up recall, 3 V / 5 V part
  localparam int T_FA_LO_MS     = 40;  // power-up recall, 2.5 V part
  localparam int T_WAKE_HI_MS   = 20;  // wake time, 3 V / 5 V part
  localparam int T_WAKE_LO_MS   = 40;  // wake time, 2.5 V part
  localparam int T_SLEEP_MS     = 8;   // longest sleep entry
  localparam int T_LZHSB_US     = 5;   // resume after busy pin released

  // ----------------------------------------------------------------
  // derived cycle counts (longest times round down)
  // ----------------------------------------------------------------
  localparam int DELAY_CYC  = T_DELAY_NS / CLK_PERIOD_NS;
  localparam int STORE_CYC  = T_STORE_MS * 1000 * CLK_MHZ;
  localparam int RECALL_CYC = T_RECALL_US * CLK_MHZ;
  localparam int FA_HI_CYC  = T_FA_HI_MS * 1000 * CLK_MHZ;
  localparam int FA_LO_CYC  = T_FA_LO_MS * 1000 * CLK_MHZ;
  localparam int WAKE_HI_CYC = T_WAKE_HI_MS * 1000 * CLK_MHZ;
  localparam int WAKE_LO_CYC = T_WAKE_LO_MS * 1000 * CLK_MHZ;
  localparam int SLEEP_CYC  = T_SLEEP_MS * 1000 * CLK_MHZ;
  localparam int LZHSB_CYC  = T_LZHSB_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int  TMR_W          = 24;   // holds the 40 ms count
  localparam logic AUTO_SAVE_RST = 1'b1; // auto save enabled at reset

  // sequencer states
  typedef enum logic [3:0] {
    NVST_OFF,       // supply below trigger level
    NVST_PU_RECALL, // power-up recall running
    NVST_IDLE,      // normal serial access
    NVST_GRACE,     // write grace before auto/pin store
    NVST_STORE,     // store to nonvolatile cells
    NVST_RECALL,    // software recall
    NVST_SLEEP_IN,  // entering sleep
    NVST_SLEEP,     // asleep
    NVST_WAKE       // leaving sleep
  } nvst_state_t;

endpackage

//--- nvst_timer.sv
// Purpose: loadable down counter that times sequencer phases
// Assumes: load value at least zero, loaded on a state change
// Notes:   zero_o is high once the loaded count has run out
`timescale 1ns/10ps
`default_nettype none
module nvst_timer #(
  parameter int W = 24
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         ce_i,
  // control
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  // status
  output logic              zero_o
);

  logic [W-1:0] cnt;  // remaining cycles

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // load wins over the decrement so a new phase always starts clean
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt <= '0;
    end else if (ce_i) begin
      if (load_i) begin
        cnt <= value_i;
      end else if (cnt != '0) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  assign zero_o = (cnt == '0);

endmodule
`default_nettype wire

//--- nvst_seq.sv
// Purpose: store, recall, sleep and standby sequencing of the nv memory
// Assumes: pins and serial clock are asynchronous to clk_i
// Notes:   durations run to their longest allowed figure
//
// Function
// - skip auto/pin store when nothing written
// - writes stay enabled 25 ns at auto/pin store start; code drops them once the store pin reads low, so a pin store gets none
// - ignore serial cycles during store, recall, brown-out
// - power-up recall done within 20 or 40 ms
// - store 8 ms, recall 600 us, io locked
// - act on soft command within 500 us
// - resume access within 5 us of busy release
// - sleep entered within 8 ms
// - accessible within 20 or 40 ms after wake
// - standby within 100 us of chip select high
// - sram disabled while store pin held low
`timescale 1ns/10ps
`default_nettype none
module nvst_seq
  import nvst_pkg::*;
#(
  parameter bit LOW_VOLT_PART = 1'b0,        // 2.5 V part timing
  parameter int STORE_CYCLES  = STORE_CYC,   // store length
  parameter int RECALL_CYCLES = RECALL_CYC,  // software recall length
  parameter int FA_HI_CYCLES  = FA_HI_CYC,   // power-up recall, hi part
  parameter int FA_LO_CYCLES  = FA_LO_CYC,   // power-up recall, lo part
  parameter int WAKE_HI_CYCLES = WAKE_HI_CYC, // wake, hi part
  parameter int WAKE_LO_CYCLES = WAKE_LO_CYC, // wake, lo part
  parameter int SLEEP_CYCLES  = SLEEP_CYC    // sleep entry
) (
  // clock, reset, enable
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic ce_i,
  // asynchronous pins
  input  wire logic supply_ok_i,     // supply above trigger level
  input  wire logic hw_store_busy_pin_i, // busy pin level seen
  input  wire logic cs_n_i,          // serial chip select
  input  wire logic sck_i,           // serial clock from host
  // same-domain requests (one-cycle pulses)
  input  wire logic sram_write_i,    // an sram write took place
  input  wire logic soft_store_i,    // software store command
  input  wire logic soft_recall_i,   // software recall command
  input  wire logic auto_on_i,       // enable power_down_auto_save
  input  wire logic auto_off_i,      // disable power_down_auto_save
  input  wire logic sleep_cmd_i,     // sleep instruction
  // busy pin drive (open drain, pulls low)
  output logic      hw_store_busy_pin_o,
  output logic      hw_store_busy_pin_oe_o,
  // status and gating
  output logic      read_write_inhibit_o, // serial access locked
  output logic      serial_edge_o,   // accepted serial clock edge
  output logic      sram_enable_o,   // sram array enabled
  output logic      sram_write_en_o, // sram writes enabled
  output logic      store_active_o,  // store in progress
  output logic      recall_active_o, // any recall in progress
  output logic      auto_save_en_o,  // power_down_auto_save armed
  output logic      sleep_o,         // in sleep state
  output logic      standby_o        // in standby state
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync_a;   // first stage, read only by sync_b
  logic [3:0] sync_b;   // second stage, safe to use
  logic       pin_d;    // delayed store pin for edge detect
  logic       sck_d;    // delayed serial clock
  logic       cs_d;     // delayed chip select

  // two flops per pin; all state freezes while ce_i is low
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      // supply reads low until really seen, so no phantom power-up
      sync_a <= 4'h7;
      sync_b <= 4'h7;
      pin_d  <= 1'b1;
      sck_d  <= 1'b1;
      cs_d   <= 1'b1;
    end else if (ce_i) begin
      sync_a <= {supply_ok_i, hw_store_busy_pin_i, cs_n_i, sck_i};
      sync_b <= sync_a;
      pin_d  <= sync_b[2];
      sck_d  <= sync_b[0];
      cs_d   <= sync_b[1];
    end
  end

  wire pwr_ok   = sync_b[3];  // supply above trigger, synced
  wire pin_lvl  = sync_b[2];  // store pin level, synced
  wire cs_n     = sync_b[1];  // chip select, synced
  wire sck      = sync_b[0];  // serial clock, synced
  wire pin_fall = pin_d & ~pin_lvl;  // store pin request edge
  wire sck_rise = ~sck_d & sck;      // serial clock edge
  wire cs_fall  = cs_d & ~cs_n;      // select edge, wakes from sleep

  // ----------------------------------------------------------------
  // state and flags
  // ----------------------------------------------------------------
  nvst_state_t state;       // sequencer state
  nvst_state_t next_state;  // its next value
  logic        dirty;       // sram written since last nv cycle
  logic        auto_en;     // power_down_auto_save armed
  logic        pin_store;   // current store is auto or pin kind
  logic        next_pin_store;
  logic        tmr_zero;    // phase timer ran out

  // round a cycle count to a timer load value (state lasts n cycles)
  function automatic logic [TMR_W-1:0] tload(input int n);
    tload = (n > 1) ? TMR_W'(n - 1) : '0;
  endfunction

  wire in_lock = (state != NVST_IDLE) && (state != NVST_SLEEP);
  wire idle    = (state == NVST_IDLE);
  // auto/pin store only when something was written
  wire do_auto = auto_en & dirty;
  wire do_pin  = pin_fall & dirty;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_pin_store = pin_store;
    case (state)
      NVST_OFF: begin
        if (pwr_ok) begin
          next_state = NVST_PU_RECALL;
        end
      end
      NVST_PU_RECALL: begin
        if (!pwr_ok) begin
          next_state = NVST_OFF;
        end else if (tmr_zero) begin
          next_state = NVST_IDLE;
        end
      end
      NVST_IDLE, NVST_SLEEP_IN, NVST_SLEEP, NVST_WAKE, NVST_RECALL: begin
        if (!pwr_ok) begin
          // brown-out: save only if armed and dirty
          next_state     = do_auto ? NVST_GRACE : NVST_OFF;
          next_pin_store = do_auto;
        end else if (idle && do_pin) begin
          next_state     = NVST_GRACE;
          next_pin_store = 1'b1;
        end else if (idle && soft_store_i) begin
          next_state     = NVST_STORE;
          next_pin_store = 1'b0;
        end else if (idle && soft_recall_i) begin
          next_state = NVST_RECALL;
        end else if (idle && sleep_cmd_i) begin
          next_state = NVST_SLEEP_IN;
        end else if (state == NVST_SLEEP_IN && tmr_zero) begin
          next_state = NVST_SLEEP;
        end else if (state == NVST_SLEEP && cs_fall) begin
          next_state = NVST_WAKE;
        end else if (state != NVST_IDLE && state != NVST_SLEEP
                     && tmr_zero) begin
          next_state = NVST_IDLE;
        end
      end
      NVST_GRACE: begin
        if (tmr_zero) begin
          next_state = NVST_STORE;
        end
      end
      NVST_STORE: begin
        // release the lock on the same edge that the busy pin lets go
        if (tmr_zero) begin
          next_state = pwr_ok ? NVST_IDLE : NVST_OFF;
        end
      end
      default: begin
        next_state = NVST_OFF;
      end
    endcase
  end

  // phase length chosen from the state being entered
  logic [TMR_W-1:0] next_load;
  always_comb begin
    case (next_state)
      NVST_PU_RECALL: next_load = LOW_VOLT_PART ? tload(FA_LO_CYCLES)
                                                : tload(FA_HI_CYCLES);
      NVST_GRACE:     next_load = tload(DELAY_CYC);
      NVST_STORE:     next_load = tload(STORE_CYCLES);
      NVST_RECALL:    next_load = tload(RECALL_CYCLES);
      NVST_SLEEP_IN:  next_load = tload(SLEEP_CYCLES);
      NVST_WAKE:      next_load = LOW_VOLT_PART ? tload(WAKE_LO_CYCLES)
                                                : tload(WAKE_HI_CYCLES);
      default:        next_load = '0;
    endcase
  end

  wire tmr_load = (next_state != state);

  nvst_timer #(
    .W (TMR_W)
  ) u_timer (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .load_i  (tmr_load),
    .value_i (next_load),
    .zero_o  (tmr_zero)
  );

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state     <= NVST_OFF;
      pin_store <= 1'b0;
    end else if (ce_i) begin
      state     <= next_state;
      pin_store <= next_pin_store;
    end
  end

  // nv cycle start clears the written flag; a write in that cycle wins
  wire nv_begin = tmr_load && (next_state == NVST_STORE
                  || next_state == NVST_RECALL
                  || next_state == NVST_PU_RECALL);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      dirty <= 1'b0;
    end else if (ce_i) begin
      if (sram_write_i) begin
        dirty <= 1'b1;
      end else if (nv_begin) begin
        dirty <= 1'b0;
      end
    end
  end

  // auto save arming by soft command; enable beats disable
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      auto_en <= AUTO_SAVE_RST;
    end else if (ce_i && idle) begin
      if (auto_on_i) begin
        auto_en <= 1'b1;
      end else if (auto_off_i) begin
        auto_en <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  wire busy_drv = pin_store && (state == NVST_GRACE
                  || state == NVST_STORE);

  assign hw_store_busy_pin_o    = 1'b0;      // open drain, only pulls low
  assign hw_store_busy_pin_oe_o = busy_drv;
  // brown-out, store and recall all block the serial port
  assign read_write_inhibit_o   = in_lock | ~pwr_ok;
  // gated by ce_i so a frozen edge is not counted over and over
  assign serial_edge_o = sck_rise & ~cs_n & idle & pwr_ok & ce_i;
  // pin held low keeps the array off; grace keeps it on for a write
  assign sram_enable_o   = pin_lvl
                           & (~in_lock | state == NVST_GRACE);
  // grace window lets a write under way finish
  assign sram_write_en_o = (idle | state == NVST_GRACE)
                           & pin_lvl;
  assign store_active_o  = (state == NVST_STORE);
  assign recall_active_o = (state == NVST_RECALL)
                           | (state == NVST_PU_RECALL);
  assign auto_save_en_o  = auto_en;
  assign sleep_o         = (state == NVST_SLEEP);
  assign standby_o       = idle & cs_n;

endmodule
`default_nettype wire

//--- nvst_seq_properties.sv
// Purpose: port checks of the nv store/recall sequencer
// Assumes: one clock domain; frozen cycles are not counted
// Notes:   phase lengths use the dut's own parameters
`timescale 1ns/10ps
`default_nettype none
module nvst_seq_chk #(
  parameter int STORE_CYCLES  = 20,
  parameter int RECALL_CYCLES = 20,
  parameter int FA_HI_CYCLES  = 20,
  parameter int SLEEP_CYCLES  = 20
) (
  // clock, reset, pins
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic supply_ok_i,
  input wire logic hw_store_busy_pin_i,
  input wire logic sleep_cmd_i,
  // outputs watched
  input wire logic hw_store_busy_pin_oe_o,
  input wire logic read_write_inhibit_o,
  input wire logic serial_edge_o,
  input wire logic sram_write_en_o,
  input wire logic store_active_o,
  input wire logic recall_active_o,
  input wire logic sleep_o
);
  localparam int SLEEP_LIM = SLEEP_CYCLES + 2; // sleep entry bound
  logic [23:0] st_cnt; // store run length
  logic [23:0] rc_cnt; // recall run length
  wire         idle = !read_write_inhibit_o && !sleep_o; // open, awake
  // --------------------------------------------
  // run-length counters, cleared when phase off
  // --------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_cnt <= '0;
      rc_cnt <= '0;
    end else if (ce_i) begin
      st_cnt <= store_active_o ? st_cnt + 24'h1 : 24'h0;
      rc_cnt <= recall_active_o ? rc_cnt + 24'h1 : 24'h0;
    end
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i || !ce_i);
  property p_grace;
    $rose(hw_store_busy_pin_oe_o) |-> (!store_active_o)[*5] ##1 store_active_o;
  endproperty
  a_grace: assert property (p_grace) else $error("grace length");
  property p_no_edge;
    read_write_inhibit_o |-> !serial_edge_o;
  endproperty
  a_no_edge: assert property (p_no_edge) else $error("edge while locked");
  property p_recall_len;
    $fell(recall_active_o) && rc_cnt != 0 |->
      (rc_cnt == RECALL_CYCLES || rc_cnt == FA_HI_CYCLES);
  endproperty
  a_recall_len: assert property (p_recall_len) else $error("recall len");
  property p_store_len;
    $fell(store_active_o) && st_cnt != 0 |-> st_cnt == STORE_CYCLES;
  endproperty
  a_store_len: assert property (p_store_len) else $error("store len");
  property p_resume;
    $fell(hw_store_busy_pin_oe_o) && supply_ok_i |->
      ##[0:999] !read_write_inhibit_o;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume");
  property p_sleep;
    sleep_cmd_i && idle && supply_ok_i |-> ##[1:SLEEP_LIM] sleep_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep late");
  property p_sram_off;
    (!hw_store_busy_pin_i && !hw_store_busy_pin_oe_o)[*3] |->
      ##[0:2] !sram_write_en_o;
  endproperty
  a_sram_off: assert property (p_sram_off) else $error("sram on");
  property p_busy;
    $fell(store_active_o) |-> !hw_store_busy_pin_oe_o;
  endproperty
  a_busy: assert property (p_busy) else $error("busy held");
  c_pin: cover property ($rose(hw_store_busy_pin_oe_o));
  c_rc: cover property ($fell(recall_active_o));
  c_sleep: cover property ($rose(sleep_o));
endmodule
bind nvst_seq nvst_seq_chk #(.STORE_CYCLES(STORE_CYCLES),
  .RECALL_CYCLES(RECALL_CYCLES), .FA_HI_CYCLES(FA_HI_CYCLES),
  .SLEEP_CYCLES(SLEEP_CYCLES)) u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
  .ce_i(ce_i),
  .supply_ok_i(supply_ok_i), .hw_store_busy_pin_i(hw_store_busy_pin_i),
  .sleep_cmd_i(sleep_cmd_i),
  .hw_store_busy_pin_oe_o(hw_store_busy_pin_oe_o),
  .read_write_inhibit_o(read_write_inhibit_o),
  .serial_edge_o(serial_edge_o), .sram_write_en_o(sram_write_en_o),
  .store_active_o(store_active_o), .recall_active_o(recall_active_o),
  .sleep_o(sleep_o));
`default_nettype wire

//--- nvst_host.sv
// Purpose: serial host model for the nv sequencer bench
// Assumes: store pin has a pull-up; host clock idles low
// Notes:   clock runs only inside frames
`timescale 1ns/10ps
`default_nettype none
module nvst_host (
  // device side of busy pin
  input  wire logic dev_oe_i,
  input  wire logic dev_pin_i,
  // serial lines, resolved pin
  output logic      cs_n_o,
  output logic      sck_o,
  output wire logic pin_o
);
  logic pull; // host sinks the store pin
  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    pull   = 1'b0;
  end
  // open drain: pull-up wins when nobody sinks
  assign pin_o = ((dev_oe_i && !dev_pin_i) || pull) ? 1'b0 : 1'b1;
  // 64 ns period stays under the clock-read limit
  task automatic frame(input int n);
    cs_n_o = 1'b0;
    #32;
    repeat (n) begin
      sck_o = 1'b1;
      #32;
      sck_o = 1'b0;
      #32;
    end
    cs_n_o = 1'b1;
  endtask
  // store request, held far past the minimum width
  task automatic hw_store(input int ns);
    pull = 1'b1;
    #(ns);
    pull = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- nv_store_recall_timing_tb.sv
// Purpose: self-checking bench for the nv store/recall sequencer
// Assumes: every hi-part phase timer but the grace (DELAY_CYC) shortened to N cycles
// Notes:   host model drives chip select, clock and store pin
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
  n_mismatch++; $display("FAIL %0t got %h exp %h", $time, g, e); end end
`define WAIT(c, m) for (int w = 0; !(c) && w < m; w++) tick(1);
`define LEN(c) for (k = 0; (c) && k < 500; k++) tick(1);
module nv_store_recall_timing_tb;
  localparam int N = 20; // shortened phase length
  logic clk_i, rstn_i, supply_ok_i, sram_write_i, soft_store_i;
  logic soft_recall_i, auto_on_i, auto_off_i, sleep_cmd_i, ce_i;
  logic pin_o, pin_oe, read_write_inhibit, s_edge, wr_en, st_act, rc_act;
  logic auto_en, sleep, standby, sram_en;
  wire  cs_n, sck, pin;
  int   n_mismatch, n_compared, n_edge, cyc, k;
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // accepted serial edges and hang guard
  always @(posedge clk_i) begin
    if (s_edge === 1'b1) n_edge++;
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  nvst_host host (.dev_oe_i(pin_oe), .dev_pin_i(pin_o), .cs_n_o(cs_n),
    .sck_o(sck), .pin_o(pin));
  nvst_seq #(.STORE_CYCLES(N), .RECALL_CYCLES(N), .FA_HI_CYCLES(N),
    .WAKE_HI_CYCLES(N), .SLEEP_CYCLES(N)) dut (.clk_i(clk_i),
    .rstn_i(rstn_i), .ce_i(ce_i),
    .supply_ok_i(supply_ok_i), .hw_store_busy_pin_i(pin), .cs_n_i(cs_n),
    .sck_i(sck), .sram_write_i(sram_write_i), .soft_store_i(soft_store_i),
    .soft_recall_i(soft_recall_i), .auto_on_i(auto_on_i),
    .auto_off_i(auto_off_i), .sleep_cmd_i(sleep_cmd_i),
    .hw_store_busy_pin_o(pin_o), .hw_store_busy_pin_oe_o(pin_oe),
    .read_write_inhibit_o(read_write_inhibit), .serial_edge_o(s_edge),
    .sram_enable_o(sram_en),
    .sram_write_en_o(wr_en), .store_active_o(st_act),
    .recall_active_o(rc_act), .auto_save_en_o(auto_en), .sleep_o(sleep),
    .standby_o(standby));
  task automatic stop_test;
    if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // supply rise; a frame sent mid-recall must be dropped
  task automatic t_powerup;
    fork host.frame(1); join_none
    supply_ok_i = 1'b1;
    `WAIT(rc_act, 10)
    `CHK(read_write_inhibit, 1'b1)
    `LEN(rc_act)
    `CHK(k, N)
    tick(20);
    `CHK(n_edge, 0)
  endtask
  task automatic t_serial;
    int e0;
    e0 = n_edge;
    host.frame(4);
    tick(4);
    `CHK(n_edge - e0, 4)
    `CHK(standby, 1'b1)
    `CHK(sram_en, 1'b1)
  endtask
  task automatic t_pin_clean;
    tick(4); // let the released pin be seen high, so a fall is found
    host.hw_store(40);
    tick(10);
    `CHK(pin_oe, 1'b0)
    `CHK(st_act, 1'b0)
  endtask
  task automatic t_pin_store;
    sram_write_i = 1'b1;
    tick(1);
    sram_write_i = 1'b0;
    fork host.hw_store(40); join_none
    `WAIT(pin_oe, 10)
    `CHK(wr_en, 1'b0)
    `CHK(sram_en, 1'b0)
    `WAIT(st_act, 10)
    `CHK(pin, 1'b0)
    `LEN(st_act)
    `CHK(k, N)
    `CHK(pin_oe, 1'b0)
    `CHK(read_write_inhibit, 1'b0)
  endtask
  // software store or recall with a frame thrown at it
  task automatic t_soft(input logic rec);
    int e0;
    e0 = n_edge;
    soft_store_i = !rec;
    soft_recall_i = rec;
    tick(1);
    soft_store_i = 1'b0;
    soft_recall_i = 1'b0;
    fork host.frame(1); join_none
    `CHK(rec ? rc_act : st_act, 1'b1)
    `CHK(pin_oe, 1'b0)
    `LEN(rec ? rc_act : st_act)
    `CHK(k, N)
    tick(20);
    `CHK(n_edge - e0, 0)
  endtask
  // freeze mid-store: the frozen cycles stretch the store
  task automatic t_freeze;
    soft_store_i = 1'b1;
    tick(1);
    soft_store_i = 1'b0;
    tick(4);
    ce_i = 1'b0;
    tick(10);
    `CHK(st_act, 1'b1)
    ce_i = 1'b1;
    `LEN(st_act)
    `CHK(k, N - 4)
  endtask
  task automatic t_sleep;
    sleep_cmd_i = 1'b1;
    tick(1);
    sleep_cmd_i = 1'b0;
    `WAIT(sleep, N + 4)
    `CHK(sleep, 1'b1)
    host.frame(1);
    `CHK(read_write_inhibit, 1'b1)
    `WAIT(!read_write_inhibit, N)
    `CHK(sleep, 1'b0)
    `CHK(read_write_inhibit, 1'b0)
  endtask
  // brown-out after a write, auto save off or on
  task automatic t_brown(input logic auto);
    auto_on_i = auto;
    auto_off_i = !auto;
    tick(1);
    auto_on_i = 1'b0;
    auto_off_i = 1'b0;
    `CHK(auto_en, auto)
    sram_write_i = 1'b1;
    tick(1);
    sram_write_i = 1'b0;
    supply_ok_i = 1'b0;
    tick(8);
    `CHK(read_write_inhibit, 1'b1)
    `CHK(pin_oe, auto)
    tick(40);
    `CHK(pin_oe, 1'b0)
    supply_ok_i = 1'b1;
    `WAIT(rc_act, 10)
    `LEN(rc_act)
    `CHK(k, N)
  endtask
  initial begin
    {rstn_i, supply_ok_i, sram_write_i, soft_store_i} = '0;
    {soft_recall_i, auto_on_i, auto_off_i, sleep_cmd_i} = '0;
    {n_mismatch, n_compared, n_edge, cyc, k} = '0;
    ce_i = 1'b1;
    tick(5);
    rstn_i = 1'b1;
    t_powerup();
    t_serial();
    t_pin_clean();
    t_pin_store();
    t_pin_clean();
    t_soft(1'b0);
    t_soft(1'b1);
    t_freeze();
    t_sleep();
    t_brown(1'b0);
    t_brown(1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
